// file: hbp_dev.sv
// Device end: serial status read responder and parallel byte handshake
`timescale 1ns/100ps

// What this block does
// - Master polls buffer state with status reads
// - Status byte then zero trailing bit shift out
// - Bits 0,1 flags; bits 4,5 interrupt enables
// - Host trusts status only within its transaction
// - Host still checks per-transaction status bits
// - Data-available low when readable; host strobes read
// - Space-available low when room; host strobes write
// - Drive byte while read low, advance on fall
// - Capture bus byte on write strobe fall
// - Data-available held high 80 ns after read
// - Space-available held high 80 ns after write
// - Status read sends direction 1, address 1
// - Thirteen serial clocks per transaction
// - Chip select may stay high between status reads
module hbp_dev (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // Link to the host
  hbp_if.dev                               lnk,
  // Receive buffer fill side
  input  wire logic [hbp_pkg::BYTE_W-1:0]  rx_in_data,
  input  wire logic                        rx_in_valid,
  output logic                             rx_in_ready,
  // Transmit buffer drain side
  output logic [hbp_pkg::BYTE_W-1:0]       tx_out_data,
  output logic                             tx_out_valid,
  input  wire logic                        tx_out_ready,
  // Interrupt enable levels reported in the status byte
  input  wire logic                        rx_full_irq_enable,
  input  wire logic                        tx_empty_irq_enable
);
  import hbp_pkg::*;

  // ==========================================================
  // Declarations
  hbp_dstate_t       sp_state_r;
  hbp_dstate_t       sp_state_nxt;
  logic [CNT_W-1:0]  sp_bit_r;
  logic [CNT_W-1:0]  sp_bit_nxt;
  logic              sp_dir_r;
  logic              sp_dir_nxt;
  logic [BYTE_W:0]   sp_sh_r;
  logic [BYTE_W:0]   sp_sh_nxt;
  logic              sdo_r;
  logic              sdo_nxt;
  logic              sclk_q_r;
  logic              sclk_rise;
  logic [BYTE_W-1:0] stat_byte;
  logic [BYTE_W-1:0] sp_byte;
  logic              sp_trail;

  logic              rd_q_r;
  logic              rd_fall;
  logic              rd_rise;
  logic              rx_full_r;
  logic              rx_full_nxt;
  logic [BYTE_W-1:0] rx_hold_r;
  logic [BYTE_W-1:0] rx_hold_nxt;
  logic [BYTE_W-1:0] rd_out_r;
  logic [BYTE_W-1:0] rd_out_nxt;
  logic              dev_oe_n_r;
  logic              dev_oe_n_nxt;
  logic [CNT_W-1:0]  rx_cnt_r;
  logic [CNT_W-1:0]  rx_cnt_nxt;
  logic              rx_avail_n_r;
  logic              rx_avail_n_nxt;
  logic              rx_ready_r;
  logic              rx_ready_nxt;

  logic              wr_q_r;
  logic              wr_fall;
  logic              tx_full_r;
  logic              tx_full_nxt;
  logic [BYTE_W-1:0] tx_hold_r;
  logic [BYTE_W-1:0] tx_hold_nxt;
  logic [CNT_W-1:0]  tx_cnt_r;
  logic [CNT_W-1:0]  tx_cnt_nxt;
  logic              tx_space_n_r;
  logic              tx_space_n_nxt;

  // ==========================================================
  // Outputs, each straight from a flip-flop
  assign lnk.serial_data_out  = sdo_r;
  assign lnk.rx_data_avail_n  = rx_avail_n_r;
  assign lnk.tx_space_avail_n = tx_space_n_r;
  assign lnk.dev_data         = rd_out_r;
  assign lnk.dev_oe_n         = dev_oe_n_r;
  assign rx_in_ready          = rx_ready_r;
  assign tx_out_valid         = tx_full_r;
  assign tx_out_data          = tx_hold_r;

  // Edge detects on pins that are synchronous to pclk
  assign sclk_rise = lnk.sclk & ~sclk_q_r;
  assign rd_fall   = rd_q_r & ~lnk.rd_n;
  assign rd_rise   = ~rd_q_r & lnk.rd_n;
  assign wr_fall   = wr_q_r & ~lnk.wr;

  // ==========================================================
  // Status byte, flags taken from the pin registers themselves
  always_comb begin
    stat_byte          = '0;
    stat_byte[ST_RXF]  = rx_avail_n_r;
    stat_byte[ST_TXE]  = tx_space_n_r;
    stat_byte[ST_RXIE] = rx_full_irq_enable;
    stat_byte[ST_TXIE] = tx_empty_irq_enable;
  end

  // ==========================================================
  // Serial responder, stepping once per sampled clock rise
  always_comb begin
    sp_state_nxt = sp_state_r;
    sp_bit_nxt   = sp_bit_r;
    sp_dir_nxt   = sp_dir_r;
    sp_sh_nxt    = sp_sh_r;
    sdo_nxt      = sdo_r;
    // Data transfers are not served here; they answer all ones and a failing status bit
    sp_byte      = NOSTAT_BYTE;
    sp_trail     = TRAIL_NOSTAT;
    if (sp_dir_r && lnk.serial_data_in) begin
      sp_byte  = stat_byte;
      sp_trail = TRAIL_STATUS;
    end
    if (sclk_rise) begin
      case (sp_state_r)
        DS_IDLE: begin
          sdo_nxt = 1'b0;
          // A held chip select simply waits for the next start bit
          if (lnk.cs && lnk.serial_data_in) begin
            sp_state_nxt = DS_XFER;
            sp_bit_nxt   = '0;
          end
        end
        DS_XFER: begin
          sp_bit_nxt = sp_bit_r + 1'b1;
          if (!lnk.cs) begin
            // Dropped select aborts the frame rather than hanging mid-byte
            sp_state_nxt = DS_IDLE;
            sdo_nxt      = 1'b0;
          end else begin
            case (sp_bit_nxt)
              SPI_BIT_DIR: begin
                sp_dir_nxt = lnk.serial_data_in;
              end
              SPI_BIT_ADDR: begin
                sdo_nxt   = sp_byte[BYTE_W-1];
                sp_sh_nxt = {sp_byte[BYTE_W-2:0], sp_trail, 1'b0};
              end
              SPI_BIT_END: begin
                sp_state_nxt = DS_IDLE;
                sdo_nxt      = 1'b0;
              end
              default: begin
                // MSB first, trailing bit after bit 0
                sdo_nxt   = sp_sh_r[BYTE_W];
                sp_sh_nxt = {sp_sh_r[BYTE_W-1:0], 1'b0};
              end
            endcase
          end
        end
        default: sp_state_nxt = DS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_state_r <= DS_IDLE;
      sp_bit_r   <= '0;
      sp_dir_r   <= 1'b0;
      sp_sh_r    <= '0;
      sdo_r      <= 1'b0;
      sclk_q_r   <= 1'b0;
    end else begin
      sp_state_r <= sp_state_nxt;
      sp_bit_r   <= sp_bit_nxt;
      sp_dir_r   <= sp_dir_nxt;
      sp_sh_r    <= sp_sh_nxt;
      sdo_r      <= sdo_nxt;
      sclk_q_r   <= lnk.sclk;
    end
  end

  // ==========================================================
  // Parallel read side: one holding byte behind the output byte
  always_comb begin
    rx_full_nxt = rx_full_r;
    rx_hold_nxt = rx_hold_r;
    rd_out_nxt  = rd_out_r;
    rx_cnt_nxt  = (rx_cnt_r != '0) ? rx_cnt_r - 1'b1 : rx_cnt_r;
    if (rd_fall && rx_full_r) begin
      rd_out_nxt  = rx_hold_r;
      rx_full_nxt = 1'b0;
    end else if (rx_in_valid && rx_ready_r) begin
      rx_hold_nxt = rx_in_data;
      rx_full_nxt = 1'b1;
    end
    if (rd_rise) begin
      rx_cnt_nxt = FLAG_HOLD_CNT;
    end
    dev_oe_n_nxt   = lnk.rd_n;
    // Flag stays high through the strobe and the hold-off after it
    rx_avail_n_nxt = ~rx_full_nxt | (rx_cnt_nxt != '0) | ~lnk.rd_n;
    rx_ready_nxt   = ~rx_full_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q_r       <= 1'b1;
      rx_full_r    <= 1'b0;
      rx_hold_r    <= '0;
      rd_out_r     <= '0;
      dev_oe_n_r   <= 1'b1;
      rx_cnt_r     <= '0;
      rx_avail_n_r <= 1'b1;
      rx_ready_r   <= 1'b0;
    end else begin
      rd_q_r       <= lnk.rd_n;
      rx_full_r    <= rx_full_nxt;
      rx_hold_r    <= rx_hold_nxt;
      rd_out_r     <= rd_out_nxt;
      dev_oe_n_r   <= dev_oe_n_nxt;
      rx_cnt_r     <= rx_cnt_nxt;
      rx_avail_n_r <= rx_avail_n_nxt;
      rx_ready_r   <= rx_ready_nxt;
    end
  end

  // ==========================================================
  // Parallel write side: a strobe into a full buffer is dropped
  always_comb begin
    tx_full_nxt = tx_full_r;
    tx_hold_nxt = tx_hold_r;
    tx_cnt_nxt  = (tx_cnt_r != '0) ? tx_cnt_r - 1'b1 : tx_cnt_r;
    if (tx_full_r && tx_out_ready) begin
      tx_full_nxt = 1'b0;
    end else if (wr_fall && !tx_full_r) begin
      tx_hold_nxt = lnk.par_data;
      tx_full_nxt = 1'b1;
    end
    if (wr_fall) begin
      tx_cnt_nxt = FLAG_HOLD_CNT;
    end
    tx_space_n_nxt = tx_full_nxt | (tx_cnt_nxt != '0) | lnk.wr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q_r       <= 1'b0;
      tx_full_r    <= 1'b0;
      tx_hold_r    <= '0;
      tx_cnt_r     <= '0;
      tx_space_n_r <= 1'b1;
    end else begin
      wr_q_r       <= lnk.wr;
      tx_full_r    <= tx_full_nxt;
      tx_hold_r    <= tx_hold_nxt;
      tx_cnt_r     <= tx_cnt_nxt;
      tx_space_n_r <= tx_space_n_nxt;
    end
  end

endmodule : hbp_dev

// file: hbp_host.sv
// Host end: APB-controlled status poller and parallel strobe driver
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps
module hbp_host (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [hbp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [hbp_pkg::DATA_W-1:0]  pwdata,
  output logic      [hbp_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Interrupt
  output logic                             irq,
  // Link to the device
  hbp_if.host                              lnk
);
  import hbp_pkg::*;

  // ==========================================================
  // Declarations
  hbp_hstate_t       st_r, st_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [CNT_W-1:0]  div_r, div_nxt;
  logic [CNT_W-1:0]  bit_r, bit_nxt;
  logic              sclk_r, sclk_nxt;
  logic              cs_r, cs_nxt;
  logic              sdi_r, sdi_nxt;
  logic [BYTE_W-1:0] rsh_r, rsh_nxt;
  logic [BYTE_W-1:0] sbyte_r, sbyte_nxt;
  logic              strail_r, strail_nxt;
  logic [BYTE_W-1:0] rbyte_r, rbyte_nxt;
  logic [BYTE_W-1:0] wbyte_r, wbyte_nxt;
  logic              rd_n_r, rd_n_nxt;
  logic              wr_r, wr_nxt;
  logic              oe_n_r, oe_n_nxt;
  logic [IRQ_W-1:0]  ev;
  logic [IRQ_W-1:0]  ist_r, ist_nxt;
  logic [IRQ_W-1:0]  ien_r, ien_nxt;
  logic              irq_r, irq_nxt;
  logic [DATA_W-1:0] prdata_r, prdata_nxt;
  logic              pready_r, pready_nxt;
  logic              pslverr_r, pslverr_nxt;
  logic [DATA_W-1:0] stat_word;
  logic              apb_wr;
  logic              cmd_go;
  logic              tick;

  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign irq               = irq_r;
  assign lnk.sclk          = sclk_r;
  assign lnk.cs            = cs_r;
  assign lnk.serial_data_in = sdi_r;
  assign lnk.rd_n          = rd_n_r;
  assign lnk.wr            = wr_r;
  assign lnk.host_data     = wbyte_r;
  assign lnk.host_oe_n     = oe_n_r;

  // Write takes effect only at the completing access edge
  assign apb_wr = psel & penable & pready_r & pwrite & ~pslverr_r;
  // Commands while busy are dropped, software polls the busy bit
  assign cmd_go = apb_wr && (paddr == REG_CMD) && (st_r == H_IDLE);
  assign tick   = (div_r == '0);

  always_comb begin
    stat_word                                = '0;
    stat_word[STAT_BUSY]                     = (st_r != H_IDLE);
    stat_word[STAT_TRAIL]                    = strail_r;
    stat_word[STAT_SBYTE_LSB +: BYTE_W]      = sbyte_r;
    stat_word[STAT_RBYTE_LSB +: BYTE_W]      = rbyte_r;
  end

  // ==========================================================
  // APB slave and interrupt; answer in the first access cycle
  always_comb begin
    pready_nxt  = psel & ~penable;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    if (pready_nxt) begin
      prdata_nxt = '0;
      case (paddr)
        REG_CMD, REG_INT_CLR: prdata_nxt = '0;
        REG_STAT:             prdata_nxt = stat_word;
        REG_INT_STAT:         prdata_nxt[IRQ_W-1:0] = ist_r;
        REG_INT_EN:           prdata_nxt[IRQ_W-1:0] = ien_r;
        default:              pslverr_nxt = 1'b1;
      endcase
    end
    ien_nxt = ien_r;
    ist_nxt = ist_r;
    if (apb_wr && (paddr == REG_INT_EN)) ien_nxt = pwdata[IRQ_W-1:0];
    if (apb_wr && (paddr == REG_INT_CLR)) ist_nxt = ist_r & ~pwdata[IRQ_W-1:0];
    // A new event beats a clear in the same cycle
    ist_nxt = ist_nxt | ev;
    irq_nxt = |(ist_nxt & ien_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      ist_r     <= '0;
      ien_r     <= '0;
      irq_r     <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      ist_r     <= ist_nxt;
      ien_r     <= ien_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // ==========================================================
  // Link sequencer
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    div_nxt    = div_r;
    bit_nxt    = bit_r;
    sclk_nxt   = sclk_r;
    cs_nxt     = cs_r;
    sdi_nxt    = sdi_r;
    rsh_nxt    = rsh_r;
    sbyte_nxt  = sbyte_r;
    strail_nxt = strail_r;
    rbyte_nxt  = rbyte_r;
    wbyte_nxt  = wbyte_r;
    rd_n_nxt   = rd_n_r;
    wr_nxt     = wr_r;
    oe_n_nxt   = oe_n_r;
    ev = '0;
    case (st_r)
      H_IDLE: begin
        if (cmd_go) begin
          case (pwdata[CMD_OP_LSB +: OP_W])
            OP_STATUS: begin
              st_nxt  = H_SPI;
              cs_nxt  = 1'b1;
              sdi_nxt = 1'b1;
              bit_nxt = '0;
              div_nxt = SCLK_HALF_CNT;
            end
            OP_READ:  st_nxt = H_RD_WAIT;
            OP_WRITE: begin
              st_nxt    = H_WR_WAIT;
              wbyte_nxt = pwdata[CMD_DATA_LSB +: BYTE_W];
            end
            default: st_nxt = H_IDLE;
          endcase
        end
      end
      H_SPI: begin
        div_nxt = tick ? SCLK_HALF_CNT : div_r - 1'b1;
        if (tick && !sclk_r) begin
          sclk_nxt = 1'b1;
          if (bit_r >= SPI_BIT_FIRST && bit_r <= SPI_BIT_LAST) begin
            rsh_nxt = {rsh_r[BYTE_W-2:0], lnk.serial_data_out};
          end
          // Trailing bit is kept so software judges every transfer by its own bit
          if (bit_r == SPI_BIT_TRAIL) strail_nxt = lnk.serial_data_out;
        end else if (tick) begin
          sclk_nxt = 1'b0;
          if (bit_r == SPI_BIT_END) begin
            cs_nxt    = 1'b0;
            sdi_nxt   = 1'b0;
            st_nxt    = H_IDLE;
            sbyte_nxt = rsh_r;
            ev[IRQ_STATUS] = 1'b1;
          end else begin
            bit_nxt = bit_r + 1'b1;
            sdi_nxt = (bit_nxt <= SPI_BIT_ADDR);
          end
        end
      end
      H_RD_WAIT: begin
        if (!lnk.rx_data_avail_n) begin
          rd_n_nxt = 1'b0;
          cnt_nxt  = RD_LOW_CNT;
          st_nxt   = H_RD_LOW;
        end
      end
      H_RD_LOW: begin
        if (cnt_r == '0) begin
          rbyte_nxt = lnk.par_data;
          rd_n_nxt  = 1'b1;
          st_nxt    = H_IDLE;
          ev[IRQ_READ] = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      H_WR_WAIT: begin
        if (!lnk.tx_space_avail_n) begin
          wr_nxt   = 1'b1;
          oe_n_nxt = 1'b0;
          cnt_nxt  = STROBE_CNT;
          st_nxt   = H_WR_HIGH;
        end
      end
      H_WR_HIGH: begin
        if (cnt_r == '0) begin
          wr_nxt = 1'b0;
          st_nxt = H_WR_LOW;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      H_WR_LOW: begin
        // Data held one more cycle so the device samples it at the fall
        oe_n_nxt = 1'b1;
        st_nxt   = H_IDLE;
        ev[IRQ_WRITE] = 1'b1;
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= H_IDLE;
      cnt_r    <= '0;
      div_r    <= '0;
      bit_r    <= '0;
      sclk_r   <= 1'b0;
      cs_r     <= 1'b0;
      sdi_r    <= 1'b0;
      rsh_r    <= '0;
      sbyte_r  <= '0;
      strail_r <= 1'b0;
      rbyte_r  <= '0;
      wbyte_r  <= '0;
      rd_n_r   <= 1'b1;
      wr_r     <= 1'b0;
      oe_n_r   <= 1'b1;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      div_r    <= div_nxt;
      bit_r    <= bit_nxt;
      sclk_r   <= sclk_nxt;
      cs_r     <= cs_nxt;
      sdi_r    <= sdi_nxt;
      rsh_r    <= rsh_nxt;
      sbyte_r  <= sbyte_nxt;
      strail_r <= strail_nxt;
      rbyte_r  <= rbyte_nxt;
      wbyte_r  <= wbyte_nxt;
      rd_n_r   <= rd_n_nxt;
      wr_r     <= wr_nxt;
      oe_n_r   <= oe_n_nxt;
    end
  end

endmodule : hbp_host

// file: hbp_if.sv
// Link between the host end and the device end
`timescale 1ns/100ps
interface hbp_if;
  import hbp_pkg::*;

  logic              sclk;
  logic              cs;
  logic              serial_data_in;
  logic              serial_data_out;
  logic              rd_n;
  logic              wr;
  logic              rx_data_avail_n;
  logic              tx_space_avail_n;
  logic [BYTE_W-1:0] host_data;
  logic              host_oe_n;
  logic [BYTE_W-1:0] dev_data;
  logic              dev_oe_n;
  logic [BYTE_W-1:0] par_data;

  // Wire level of the shared byte bus; pulled high when nobody drives
  assign par_data = !dev_oe_n ? dev_data : (!host_oe_n ? host_data : BUS_IDLE);

  modport dev (
    input  sclk, cs, serial_data_in, rd_n, wr, par_data,
    output serial_data_out, rx_data_avail_n, tx_space_avail_n, dev_data, dev_oe_n
  );
  modport host (
    input  serial_data_out, rx_data_avail_n, tx_space_avail_n, par_data,
    output sclk, cs, serial_data_in, rd_n, wr, host_data, host_oe_n
  );
endinterface : hbp_if

// file: hbp_pkg.sv
// Shared constants and types for the host buffer port, both ends
package hbp_pkg;

  // ==========================================================
  // Widths
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int OP_W   = 2;
  localparam int IRQ_W  = 3;

  // ==========================================================
  // Timing, printed figures and derived cycle counts
  localparam int CLK_PERIOD_NS = 100;
  localparam int FLAG_HOLD_NS  = 80;
  localparam int STROBE_MIN_NS = 50;
  localparam int RD_VALID_NS   = 50;
  localparam int SCLK_MIN_NS   = 83;

  // Least time rounded up to whole cycles, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int FLAG_HOLD_CYC = cyc_up(FLAG_HOLD_NS);
  localparam int STROBE_CYC    = cyc_up(STROBE_MIN_NS);
  // One extra cycle covers the device's registered bus drive
  localparam int RD_LOW_CYC    = cyc_up(RD_VALID_NS) + 1;
  localparam int SCLK_HALF_CYC = cyc_up((SCLK_MIN_NS + 1) / 2);

  localparam logic [CNT_W-1:0] FLAG_HOLD_CNT = CNT_W'(FLAG_HOLD_CYC);
  localparam logic [CNT_W-1:0] STROBE_CNT    = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LOW_CNT    = CNT_W'(RD_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] SCLK_HALF_CNT = CNT_W'(SCLK_HALF_CYC - 1);

  // ==========================================================
  // Serial frame: index of the named rises among the 13 clock rises, counted from 0
  localparam logic [CNT_W-1:0] SPI_BIT_DIR   = 4'h1;
  localparam logic [CNT_W-1:0] SPI_BIT_ADDR  = 4'h2;
  localparam logic [CNT_W-1:0] SPI_BIT_FIRST = 4'h3;
  localparam logic [CNT_W-1:0] SPI_BIT_LAST  = 4'hA;
  localparam logic [CNT_W-1:0] SPI_BIT_TRAIL = 4'hB;
  localparam logic [CNT_W-1:0] SPI_BIT_END   = 4'hC;

  // Status byte fields
  localparam int ST_RXF  = 0;
  localparam int ST_TXE  = 1;
  localparam int ST_RXIE = 4;
  localparam int ST_TXIE = 5;
  localparam logic [BYTE_W-1:0] NOSTAT_BYTE  = 8'hFF;
  localparam logic              TRAIL_STATUS = 1'b0;
  localparam logic              TRAIL_NOSTAT = 1'b1;
  localparam logic [BYTE_W-1:0] BUS_IDLE     = 8'hFF;

  // ==========================================================
  // Controller registers
  localparam logic [ADDR_W-1:0] REG_CMD      = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STAT     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_INT_CLR  = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_INT_EN   = 8'h10;
  localparam int CMD_OP_LSB     = 0;
  localparam int CMD_DATA_LSB   = 8;
  localparam int STAT_BUSY      = 0;
  localparam int STAT_TRAIL     = 1;
  localparam int STAT_SBYTE_LSB = 8;
  localparam int STAT_RBYTE_LSB = 16;
  localparam int IRQ_STATUS     = 0;
  localparam int IRQ_READ       = 1;
  localparam int IRQ_WRITE      = 2;
  localparam logic [OP_W-1:0] OP_STATUS = 2'h1;
  localparam logic [OP_W-1:0] OP_READ   = 2'h2;
  localparam logic [OP_W-1:0] OP_WRITE  = 2'h3;

  // ==========================================================
  // State types
  typedef enum logic [0:0] {DS_IDLE = 1'b0, DS_XFER = 1'b1} hbp_dstate_t;
  typedef enum logic [2:0] {
    H_IDLE    = 3'h0,
    H_SPI     = 3'h1,
    H_RD_WAIT = 3'h2,
    H_RD_LOW  = 3'h3,
    H_WR_WAIT = 3'h4,
    H_WR_HIGH = 3'h5,
    H_WR_LOW  = 3'h6
  } hbp_hstate_t;

endpackage : hbp_pkg

// file: hbp_props.sv
// Link checks between host and device ends
`timescale 1ns/100ps
module hbp_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic sclk,
  input wire logic cs,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic rd_n,
  input wire logic wr,
  input wire logic rx_data_avail_n,
  input wire logic tx_space_avail_n,
  input wire logic dev_oe_n
);
  logic       sclk_r;
  logic [3:0] n_r;
  logic [3:0] n_nxt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Frame rise count, cleared while cs is low
  always_comb n_nxt = !cs ? 4'h0 : ((sclk && !sclk_r) ? n_r + 4'h1 : n_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_r    <= 4'h0;
      sclk_r <= 1'b0;
    end else begin
      n_r    <= n_nxt;
      sclk_r <= sclk;
    end
  end
  sequence s_rise;
    sclk && !sclk_r;
  endsequence
  // ==========================================
  // Serial frame
  setup_bits_a: assert property (s_rise ##0 (n_r < 4'h3) |-> serial_data_in)
    else $error("setup bit low");
  trail_zero_a: assert property (s_rise ##0 (n_r == 4'hB) |-> !serial_data_out)
    else $error("trailing bit not zero");
  frame_len_a: assert property ($fell(cs) |-> n_r == 4'hD)
    else $error("frame length wrong");
  // ==========================================
  // Parallel handshake; holdoffs guard against a stale flag
  // A byte refilled during the strobe must still wait out the holdoff
  rd_hold_a: assert property ($rose(rd_n) |-> rx_data_avail_n [*2])
    else $error("read flag not held off");
  wr_hold_a: assert property ($fell(wr) |=> tx_space_avail_n)
    else $error("write flag not held off");
  rd_drive_a: assert property (!rd_n && !$past(rd_n) |-> !dev_oe_n)
    else $error("device not driving");
  bus_free_a: assert property (rd_n && $past(rd_n) |-> dev_oe_n)
    else $error("device drives idle bus");
  rd_gate_a: assert property ($fell(rd_n) |-> !$past(rx_data_avail_n))
    else $error("read without data");
  wr_gate_a: assert property ($rose(wr) |-> !$past(tx_space_avail_n))
    else $error("write without room");
endmodule : hbp_props

// file: tb_top.sv
// Bench joining host and device ends
`timescale 1ns/100ps
module tb_top;
  import hbp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [BYTE_W-1:0] rx_in_data, tx_out_data;
  logic rx_in_valid, rx_in_ready, tx_out_valid, tx_out_ready, rx_ie, tx_ie;
  int failures, num_checks;
  hbp_if lnk ();
  hbp_host i_hbp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .lnk(lnk));
  hbp_dev i_hbp_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk), .rx_in_data(rx_in_data),
    .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .tx_out_data(tx_out_data), .tx_out_valid(tx_out_valid),
    .tx_out_ready(tx_out_ready), .rx_full_irq_enable(rx_ie), .tx_empty_irq_enable(tx_ie));
  hbp_props u_props (.pclk(pclk), .presetn(presetn), .sclk(lnk.sclk), .cs(lnk.cs), .wr(lnk.wr),
    .serial_data_in(lnk.serial_data_in), .serial_data_out(lnk.serial_data_out), .rd_n(lnk.rd_n),
    .rx_data_avail_n(lnk.rx_data_avail_n), .tx_space_avail_n(lnk.tx_space_avail_n), .dev_oe_n(lnk.dev_oe_n));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // APB cycle; waits on pready, the watchdog bounds it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input logic [1:0] op, input logic [7:0] d);
    apb(1'b1, REG_CMD, {16'h0, d, 6'h0, op});
    do apb(1'b0, REG_STAT, 32'h0); while (rd[STAT_BUSY] !== 1'b0);
  endtask : run
  // Status byte for every enable pairing
  task automatic t_status(input logic rx_n, input logic tx_n);
    for (int i = 0; i < 4; i++) begin
      {tx_ie, rx_ie} <= 2'(i);
      run(OP_STATUS, 8'h0);
      chk(32'(rd[15:8]), 32'({2'h0, tx_ie, rx_ie, 2'h0, tx_n, rx_n}));
      chk(32'(rd[STAT_TRAIL]), 32'h0);
    end
  endtask : t_status
  // Masked, enabled and cleared interrupt, then an unmapped place
  task automatic t_irq;
    run(OP_STATUS, 8'h0);
    chk(32'(irq), 32'h0);
    apb(1'b1, REG_INT_EN, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, REG_INT_CLR, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[30:0], er}, 32'h1);
  endtask : t_irq
  // Second byte waits behind the first and refills during the strobe, so the holdoff matters
  task automatic t_read;
    rx_in_data  <= 8'hA5;
    rx_in_valid <= 1'b1;
    do @(posedge pclk); while (rx_in_ready !== 1'b1);
    rx_in_data  <= 8'h5A;
    t_status(1'b0, 1'b0);
    run(OP_READ, 8'h0);
    chk(32'(rd[23:16]), 32'hA5);
    rx_in_valid <= 1'b0;
    t_status(1'b0, 1'b0);
    run(OP_READ, 8'h0);
    chk(32'(rd[23:16]), 32'h5A);
    t_status(1'b1, 1'b0);
  endtask : t_read
  // Full buffer shows no room; the second write follows once it drains
  task automatic t_write;
    run(OP_WRITE, 8'h3C);
    chk(32'({tx_out_valid, tx_out_data}), 32'h13C);
    t_status(1'b1, 1'b1);
    tx_out_ready <= 1'b1;
    @(posedge pclk);
    tx_out_ready <= 1'b0;
    run(OP_WRITE, 8'hC3);
    chk(32'({tx_out_valid, tx_out_data}), 32'h1C3);
  endtask : t_write
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #2000000;
    failures++;
    give_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, rx_in_valid, tx_out_ready, rx_ie, tx_ie} = 8'h0;
    {paddr, pwdata, rx_in_data} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_irq;
    t_status(1'b1, 1'b0);
    t_read;
    t_write;
    give_verdict;
  end
endmodule : tb_top
